// >>> common/ttc_pkg.sv
// Purpose: shared constants and types for the turbo and thermal control block
// Assumes: 40 MHz core clock, 8 cores, 16 threads, 8-bit ratios and temperatures
// Notes:   ratio and temperature encodings are plain unsigned codes
package ttc_pkg;
    localparam int NUM_CORES   = 8;
    localparam int NUM_THREADS = 16;
    localparam int RATIO_W     = 8;
    localparam int TEMP_W      = 8;

    localparam int CLK_HZ       = 40_000_000;
    localparam int SAMPLE_MS    = 1;
    localparam int SAMPLE_CYC   = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int STEP_US      = 100;
    localparam int STEP_CYC     = CLK_HZ / 1_000_000 * STEP_US;

    localparam int PKG_TURBO_DIS_BIT = 38;
    localparam int THR_TURBO_DIS_BIT = 32;

    localparam logic [1:0] POL_ALL   = 2'h0;
    localparam logic [1:0] POL_ANY   = 2'h1;
    localparam logic [1:0] POL_RSVD  = 2'h2;
    localparam logic [1:0] POL_NEVER = 2'h3;
    localparam logic [1:0] POL_RESET = POL_ANY;
    localparam logic       PKG_DIS_RESET = 1'b1;

    localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h00;

    typedef enum logic [1:0] {
        TTC_IDLE   = 2'b00,
        TTC_TRIP   = 2'b01,
        TTC_FLOOR  = 2'b11,
        TTC_MOD    = 2'b10
    } ttc_state_t;

    // per-thread vote: top-state request, turbo disable, vote suspended by deep sleep
    typedef struct packed {
        logic wants_top;
        logic turbo_dis;
        logic deep_sleep;
    } ttc_vote_t;

    typedef struct packed {
        logic [RATIO_W-1:0] floor_ratio;
        logic [RATIO_W-1:0] nominal_ratio;
        logic [RATIO_W-1:0] max_ratio;
    } ttc_ratios_t;
endpackage

// >>> design/ttc_top.sv
// Purpose: turbo grant, package ratio resolution and thermal response
// Assumes: all inputs synchronous except force_power_reduce_n and sensor temps
// Notes:   legacy uplift per active-core count comes from uplift_table input
// Functional notes
// - policy 00 all voters at top, 01 any voter, 10 reserved, 11 never
// - turbo policy resets to 01
// - package disable bit 38 overrides all thread requests
// - package disable bit resets to 1; software may clear it
// - thread withheld when its bit 32 set or below top state
// - top-state ratio never below nominal ratio
// - never pick a ratio above the power-limit ratio, except the floor ratio when that limit is below floor
// - base uplift chosen only by active core count, held until count or its uplift_table entry changes
// - sample every core temperature once per millisecond into its register
// - upward trip crossing in a sample starts package thermal response
// - response holds while any temperature at or above trip
// - hot indicator asserts while any core above trip
// - force power reduction jumps to floor ratio and starts clock modulation
// - one thermal ratio target, ignores software requests, caps resolution
// - thermal target lowered one step per interval, not at once
// - at floor with heat persisting, clock modulation is added
// - package ratio is highest core request after constraints, shared by cores
// - deep sleep drops a thread vote; light halts keep it
module ttc_top (
    input  wire logic                                   clock,
    input  wire logic                                   rst_n,
    input  wire logic                                   cfg_we,
    input  wire logic [63:0]                            cfg_feature_wdata,
    input  wire logic [1:0]                             cfg_policy_wdata,
    input  wire ttc_pkg::ttc_vote_t [ttc_pkg::NUM_THREADS-1:0] votes,
    input  wire logic [ttc_pkg::NUM_THREADS-1:0][ttc_pkg::RATIO_W-1:0] thread_ratio_req,
    input  wire logic [ttc_pkg::NUM_CORES-1:0]          core_active,
    input  wire logic [ttc_pkg::NUM_CORES-1:0][ttc_pkg::TEMP_W-1:0] core_temp,
    input  wire logic [ttc_pkg::TEMP_W-1:0]             trip_temp,
    input  wire ttc_pkg::ttc_ratios_t                   ratios,
    input  wire logic [ttc_pkg::RATIO_W-1:0]            power_limit_ratio,
    input  wire logic [ttc_pkg::NUM_CORES:0][ttc_pkg::RATIO_W-1:0] uplift_table,
    input  wire logic                                   force_power_reduce_n,
    output logic                                        package_hot_indicator_n,
    output logic                                        clock_mod_en,
    output logic [ttc_pkg::RATIO_W-1:0]                 pkg_ratio,
    output logic                                        turbo_granted,
    output logic [ttc_pkg::NUM_THREADS-1:0]             thread_turbo_ok,
    output logic [ttc_pkg::NUM_CORES-1:0][ttc_pkg::TEMP_W-1:0] core_thermo,
    output logic [ttc_pkg::RATIO_W-1:0]                 thermal_target,
    output logic                                        pkg_turbo_dis,
    output logic [1:0]                                  turbo_policy
);
    localparam int NT = ttc_pkg::NUM_THREADS;
    localparam int NC = ttc_pkg::NUM_CORES;
    localparam int RW = ttc_pkg::RATIO_W;

    logic [1:0]  fpr_sync_ff;
    logic [NC-1:0][ttc_pkg::TEMP_W-1:0] temp_s1_ff;
    logic [NC-1:0][ttc_pkg::TEMP_W-1:0] temp_s2_ff;
    logic [NC-1:0][ttc_pkg::TEMP_W-1:0] temp_s3_ff;
    logic [NC-1:0][ttc_pkg::TEMP_W-1:0] temp_q_ff;
    logic [15:0] sample_cnt_ff;
    logic [15:0] step_cnt_ff;
    logic [NC-1:0] over_ff;
    logic [NC-1:0] at_or_over_ff;
    ttc_pkg::ttc_state_t state_ff;
    ttc_pkg::ttc_state_t nxt_state;
    logic [RW-1:0] nxt_target;
    logic [3:0]    act_cnt_ff;
    logic [RW-1:0] uplift_ff;

    // configuration bits
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pkg_turbo_dis <= ttc_pkg::PKG_DIS_RESET;
            turbo_policy  <= ttc_pkg::POL_RESET;
        end
        else if (cfg_we)
        begin
            pkg_turbo_dis <= cfg_feature_wdata[ttc_pkg::PKG_TURBO_DIS_BIT];
            turbo_policy  <= cfg_policy_wdata;
        end
    end

    // vote evaluation
    wire [NT-1:0] voting;
    wire [NT-1:0] at_top;
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++)
        begin : g_vote
            assign voting[gi] = !votes[gi].deep_sleep;
            assign at_top[gi] = votes[gi].wants_top && !votes[gi].turbo_dis;
        end
    endgenerate

    wire any_voter  = |voting;
    wire all_top    = any_voter && ((at_top & voting) == voting);
    wire any_top    = |(at_top & voting);
    wire policy_ok  = (turbo_policy == ttc_pkg::POL_ALL) ? all_top :
                      (turbo_policy == ttc_pkg::POL_ANY) ? any_top : 1'b0;
    wire thermal_on = (state_ff != ttc_pkg::TTC_IDLE);
    wire grant      = !pkg_turbo_dis && policy_ok && !thermal_on;
    wire [NT-1:0] thr_ok = {NT{grant}} & at_top & voting;

    // active core count picks the legacy uplift
    logic [3:0] act_cnt;
    always_comb
    begin
        act_cnt = 4'h0;
        for (int i = 0; i < NC; i++)
            act_cnt = act_cnt + {3'h0, core_active[i]};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_cnt_ff <= 4'h0;
            uplift_ff  <= ttc_pkg::RATIO_RESET;
        end
        else if (act_cnt != act_cnt_ff || uplift_ff != uplift_table[act_cnt])
        begin
            act_cnt_ff <= act_cnt;
            uplift_ff  <= uplift_table[act_cnt];
        end
    end

    // highest voting software request
    logic [RW-1:0] max_req;
    always_comb
    begin
        max_req = ratios.floor_ratio;
        for (int i = 0; i < NT; i++)
            if (voting[i] && thread_ratio_req[i] > max_req)
                max_req = thread_ratio_req[i];
    end

    wire [RW-1:0] turbo_raw  = ratios.nominal_ratio + uplift_ff;
    wire [RW-1:0] turbo_cap  = (turbo_raw > ratios.max_ratio) ? ratios.max_ratio : turbo_raw;
    wire [RW-1:0] turbo_r    = (turbo_cap < ratios.nominal_ratio) ? ratios.nominal_ratio
                                                                  : turbo_cap;
    wire [RW-1:0] sw_ratio   = grant ? turbo_r :
                               (max_req > ratios.nominal_ratio) ? ratios.nominal_ratio
                                                                : max_req;
    wire [RW-1:0] pwr_cap    = (sw_ratio > power_limit_ratio) ? power_limit_ratio
                                                              : sw_ratio;
    wire [RW-1:0] th_cap     = (thermal_on && pwr_cap > thermal_target) ? thermal_target
                                                                         : pwr_cap;
    wire [RW-1:0] res_ratio  = (th_cap < ratios.floor_ratio) ? ratios.floor_ratio : th_cap;

    // sampling of sensors
    wire sample_tick = (sample_cnt_ff == 16'(ttc_pkg::SAMPLE_CYC - 1));
    wire step_tick   = (step_cnt_ff == 16'(ttc_pkg::STEP_CYC - 1));
    wire [NC-1:0] over_now;
    wire [NC-1:0] ge_now;
    wire [NC-1:0] temp_steady;
    wire [NC-1:0][ttc_pkg::TEMP_W-1:0] nxt_temp_q;
    // a sensor word is taken only once two synced copies agree, so a torn word never lands
    generate
        for (gi = 0; gi < NC; gi++)
        begin : g_temp
            assign temp_steady[gi] = (temp_s2_ff[gi] == temp_s3_ff[gi]);
            assign nxt_temp_q[gi]  = temp_steady[gi] ? temp_s2_ff[gi] : temp_q_ff[gi];
            assign over_now[gi]    = temp_q_ff[gi] > trip_temp;
            assign ge_now[gi]      = temp_q_ff[gi] >= trip_temp;
        end
    endgenerate

    wire fpr_on    = !fpr_sync_ff[1];
    wire trip_up   = sample_tick && |(ge_now & ~at_or_over_ff);
    wire still_hot = |at_or_over_ff;
    wire at_floor  = (thermal_target <= ratios.floor_ratio);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fpr_sync_ff   <= 2'h3;
            temp_s1_ff    <= '0;
            temp_s2_ff    <= '0;
            temp_s3_ff    <= '0;
            temp_q_ff     <= '0;
            sample_cnt_ff <= 16'h0000;
            step_cnt_ff   <= 16'h0000;
            over_ff       <= '0;
            at_or_over_ff <= '0;
            core_thermo   <= '0;
        end
        else
        begin
            fpr_sync_ff   <= {fpr_sync_ff[0], force_power_reduce_n};
            temp_s1_ff    <= core_temp;
            temp_s2_ff    <= temp_s1_ff;
            temp_s3_ff    <= temp_s2_ff;
            temp_q_ff     <= nxt_temp_q;
            sample_cnt_ff <= sample_tick ? 16'h0000 : sample_cnt_ff + 16'h0001;
            step_cnt_ff   <= (step_tick || state_ff == ttc_pkg::TTC_IDLE) ? 16'h0000
                                                                          : step_cnt_ff + 16'h0001;
            if (sample_tick)
            begin
                core_thermo   <= temp_q_ff;
                over_ff       <= over_now;
                at_or_over_ff <= ge_now;
            end
        end
    end

    // thermal response machine
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_target = thermal_target;
        case (state_ff)
            ttc_pkg::TTC_IDLE:
            begin
                nxt_target = ratios.max_ratio;
                if (fpr_on)
                begin
                    nxt_state  = ttc_pkg::TTC_MOD;
                    nxt_target = ratios.floor_ratio;
                end
                else if (trip_up)
                    nxt_state = ttc_pkg::TTC_TRIP;
            end
            ttc_pkg::TTC_TRIP:
            begin
                if (fpr_on)
                begin
                    nxt_state  = ttc_pkg::TTC_MOD;
                    nxt_target = ratios.floor_ratio;
                end
                else if (!still_hot)
                    nxt_state = ttc_pkg::TTC_IDLE;
                else if (at_floor)
                    nxt_state = ttc_pkg::TTC_FLOOR;
                else if (step_tick)
                    nxt_target = thermal_target - 8'h01;
            end
            ttc_pkg::TTC_FLOOR:
            begin
                if (fpr_on || (still_hot && step_tick))
                    nxt_state = ttc_pkg::TTC_MOD;
                else if (!still_hot)
                    nxt_state = ttc_pkg::TTC_IDLE;
            end
            ttc_pkg::TTC_MOD:
            begin
                nxt_target = ratios.floor_ratio;
                if (!fpr_on && !still_hot)
                    nxt_state = ttc_pkg::TTC_IDLE;
            end
            default:
                nxt_state = ttc_pkg::TTC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff                <= ttc_pkg::TTC_IDLE;
            thermal_target          <= ttc_pkg::RATIO_RESET;
            package_hot_indicator_n <= 1'b1;
            clock_mod_en            <= 1'b0;
            pkg_ratio               <= ttc_pkg::RATIO_RESET;
            turbo_granted           <= 1'b0;
            thread_turbo_ok         <= '0;
        end
        else
        begin
            state_ff                <= nxt_state;
            thermal_target          <= nxt_target;
            package_hot_indicator_n <= !(|over_ff);
            clock_mod_en            <= (nxt_state == ttc_pkg::TTC_MOD);
            pkg_ratio               <= res_ratio;
            turbo_granted           <= grant;
            thread_turbo_ok         <= thr_ok;
        end
    end

    property p_pkg_dis;
        @(posedge clock) disable iff (!rst_n) pkg_turbo_dis |=> !turbo_granted;
    endproperty
    a_pkg_dis: assert property (p_pkg_dis) else $error("turbo granted while disabled");

    property p_never;
        @(posedge clock) disable iff (!rst_n)
            (turbo_policy == ttc_pkg::POL_NEVER) |=> !turbo_granted;
    endproperty
    a_never: assert property (p_never) else $error("turbo under never policy");

    property p_hot;
        @(posedge clock) disable iff (!rst_n) (|over_ff) |=> !package_hot_indicator_n;
    endproperty
    a_hot: assert property (p_hot) else $error("hot indicator not asserted");

    property p_fpr;
        @(posedge clock) disable iff (!rst_n) fpr_on |=> clock_mod_en;
    endproperty
    a_fpr: assert property (p_fpr) else $error("force reduction ignored");

    property p_pwr;
        @(posedge clock) disable iff (!rst_n)
            (power_limit_ratio >= ratios.floor_ratio) |=> pkg_ratio <= $past(power_limit_ratio);
    endproperty
    a_pwr: assert property (p_pwr) else $error("ratio above power limit");

    property p_grad;
        @(posedge clock) disable iff (!rst_n)
            (state_ff == ttc_pkg::TTC_TRIP && $past(state_ff) == ttc_pkg::TTC_TRIP)
            |-> thermal_target >= $past(thermal_target) - 8'h01;
    endproperty
    a_grad: assert property (p_grad) else $error("thermal target dropped too fast");

    property p_hold;
        @(posedge clock) disable iff (!rst_n)
            (state_ff == ttc_pkg::TTC_TRIP && still_hot && !fpr_on)
            |=> state_ff != ttc_pkg::TTC_IDLE;
    endproperty
    a_hold: assert property (p_hold) else $error("left response while hot");

    property p_cap;
        @(posedge clock) disable iff (!rst_n)
            (thermal_on && thermal_target >= ratios.floor_ratio)
            |=> pkg_ratio <= $past(thermal_target);
    endproperty
    a_cap: assert property (p_cap) else $error("ratio above thermal target");

    c_grant: cover property (@(posedge clock) disable iff (!rst_n) turbo_granted);
    c_trip:  cover property (@(posedge clock) disable iff (!rst_n)
                 state_ff == ttc_pkg::TTC_TRIP ##1 state_ff == ttc_pkg::TTC_FLOOR);
    c_mod:   cover property (@(posedge clock) disable iff (!rst_n) clock_mod_en);
endmodule

// >>> tb/ttc_far_model.sv
// Purpose: far-side model of the core temperature sensors and external power-cut source
// Assumes: temperatures and the force input change on the falling clock edge
// Notes:   the force input is held low for as long as the reduction is wanted
module ttc_far_model (
    input  wire logic                                               clock,
    output logic [ttc_pkg::NUM_CORES-1:0][ttc_pkg::TEMP_W-1:0]      core_temp,
    output logic                                                    force_power_reduce_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        core_temp            = '0;
        force_power_reduce_n = 1'b1;
    end

    task automatic set_temp(input int core, input logic [ttc_pkg::TEMP_W-1:0] val);
        @(negedge clock);
        core_temp[core] = val;
    endtask

    // level held for the whole reduction, not a pulse
    task automatic set_force(input logic on);
        @(negedge clock);
        force_power_reduce_n = ~on;
    endtask
endmodule

// >>> tb/turbo_thermal_control_tb.sv
// Purpose: self-checking bench for the turbo grant and thermal response block
// Assumes: policy and disable loaded by cfg_we; sampling every 40000 cycles
// Notes:   ratios are kept close together so the thermal walk stays short
module turbo_thermal_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                                       clock;
    logic                                                       rst_n;
    logic                                                       cfg_we;
    logic [63:0]                                                cfg_feature_wdata;
    logic [1:0]                                                 cfg_policy_wdata;
    ttc_pkg::ttc_vote_t [ttc_pkg::NUM_THREADS-1:0]              votes;
    logic [ttc_pkg::NUM_THREADS-1:0][ttc_pkg::RATIO_W-1:0]      thread_ratio_req;
    logic [ttc_pkg::NUM_CORES-1:0]                              core_active;
    logic [ttc_pkg::NUM_CORES-1:0][ttc_pkg::TEMP_W-1:0]         core_temp;
    logic [ttc_pkg::TEMP_W-1:0]                                 trip_temp;
    ttc_pkg::ttc_ratios_t                                       ratios;
    logic [ttc_pkg::RATIO_W-1:0]                                power_limit_ratio;
    logic [ttc_pkg::NUM_CORES:0][ttc_pkg::RATIO_W-1:0]          uplift_table;
    logic                                                       force_power_reduce_n;
    logic                                                       package_hot_indicator_n;
    logic                                                       clock_mod_en;
    logic [ttc_pkg::RATIO_W-1:0]                                pkg_ratio;
    logic                                                       turbo_granted;
    logic [ttc_pkg::NUM_THREADS-1:0]                            thread_turbo_ok;
    logic [ttc_pkg::NUM_CORES-1:0][ttc_pkg::TEMP_W-1:0]         core_thermo;
    logic [ttc_pkg::RATIO_W-1:0]                                thermal_target;
    logic                                                       pkg_turbo_dis;
    logic [1:0]                                                 turbo_policy;
    int                                                         err_total;
    int                                                         n_checks;

    ttc_far_model FAR (.clock(clock), .core_temp(core_temp),
        .force_power_reduce_n(force_power_reduce_n));

    ttc_top DUT (.clock(clock), .rst_n(rst_n), .cfg_we(cfg_we),
        .cfg_feature_wdata(cfg_feature_wdata), .cfg_policy_wdata(cfg_policy_wdata),
        .votes(votes), .thread_ratio_req(thread_ratio_req), .core_active(core_active),
        .core_temp(core_temp), .trip_temp(trip_temp), .ratios(ratios),
        .power_limit_ratio(power_limit_ratio), .uplift_table(uplift_table),
        .force_power_reduce_n(force_power_reduce_n),
        .package_hot_indicator_n(package_hot_indicator_n), .clock_mod_en(clock_mod_en),
        .pkg_ratio(pkg_ratio), .turbo_granted(turbo_granted),
        .thread_turbo_ok(thread_turbo_ok), .core_thermo(core_thermo),
        .thermal_target(thermal_target), .pkg_turbo_dis(pkg_turbo_dis),
        .turbo_policy(turbo_policy));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_sim();
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    // a wait that used up its bound ends the run at once
    task automatic limit(input int k, input int lim, input string name);
        if (k >= lim)
        begin
            err_total++;
            $display("[FAIL] %s wait bound %0d used up", name, lim);
            end_sim();
        end
    endtask

    task automatic cfg(input logic dis, input logic [1:0] pol);
        @(negedge clock);
        cfg_we            = 1'b1;
        cfg_feature_wdata = {25'h000_0000, dis, 38'h00_0000_0000};
        cfg_policy_wdata  = pol;
        @(negedge clock);
        cfg_we = 1'b0;
        step(2);
    endtask

    task automatic t_reset();
        check("pkg_turbo_dis", 64'(pkg_turbo_dis), 64'h0000_0000_0000_0001);
        check("turbo_policy", 64'(turbo_policy), 64'h0000_0000_0000_0001);
        check("hot_n", 64'(package_hot_indicator_n), 64'h0000_0000_0000_0001);
        check("granted", 64'(turbo_granted), 64'h0000_0000_0000_0000);
    endtask

    task automatic t_policy();
        logic [3:0] exp_any;
        exp_any = 4'h2;
        for (int p = 0; p < 4; p++)
        begin
            cfg(1'b0, 2'(p));
            check("granted by policy", 64'(turbo_granted), 64'(exp_any[p]));
        end
        votes[2].wants_top = 1'b1;
        cfg(1'b0, 2'h0);
        check("granted all at top", 64'(turbo_granted), 64'h0000_0000_0000_0001);
        votes[2].wants_top  = 1'b0;
        votes[2].deep_sleep = 1'b1;
        step(2);
        check("granted sleeper", 64'(turbo_granted), 64'h0000_0000_0000_0001);
        votes[2].deep_sleep = 1'b0;
        votes[2].wants_top  = 1'b1;
    endtask

    task automatic t_disable();
        votes[0].turbo_dis = 1'b1;
        cfg(1'b0, 2'h1);
        check("thread0 ok", 64'(thread_turbo_ok[0]), 64'h0000_0000_0000_0000);
        check("thread2 ok", 64'(thread_turbo_ok[2]), 64'h0000_0000_0000_0001);
        cfg(1'b1, 2'h1);
        check("granted pkg off", 64'(turbo_granted), 64'h0000_0000_0000_0000);
        check("thread2 pkg off", 64'(thread_turbo_ok[2]), 64'h0000_0000_0000_0000);
        votes[0].turbo_dis = 1'b0;
        cfg(1'b0, 2'h1);
    endtask

    task automatic t_ratio();
        core_active = 8'h03;
        step(2);
        check("ratio two cores", 64'(pkg_ratio), 64'h0000_0000_0000_0012);
        core_active = 8'h3f;
        step(2);
        check("ratio clamp max", 64'(pkg_ratio), 64'h0000_0000_0000_0014);
        core_active       = 8'h03;
        power_limit_ratio = 8'h11;
        step(2);
        check("ratio power cap", 64'(pkg_ratio), 64'h0000_0000_0000_0011);
        power_limit_ratio = 8'hff;
        thread_ratio_req[0] = 8'h0c;
        thread_ratio_req[2] = 8'h0a;
        cfg(1'b1, 2'h1);
        check("ratio max request", 64'(pkg_ratio), 64'h0000_0000_0000_000c);
        thread_ratio_req[0] = 8'h1f;
        step(2);
        check("ratio nominal cap", 64'(pkg_ratio), 64'h0000_0000_0000_0010);
        cfg(1'b0, 2'h1);
    endtask

    task automatic t_force();
        int k;
        FAR.set_force(1'b1);
        k = 0;
        while (clock_mod_en !== 1'b1 && k < 8)
        begin
            step(1);
            k++;
        end
        limit(k, 8, "force modulation");
        step(1);
        check("force floor", 64'(pkg_ratio), 64'h0000_0000_0000_0008);
        check("force no turbo", 64'(turbo_granted), 64'h0000_0000_0000_0000);
        FAR.set_force(1'b0);
        k = 0;
        while (clock_mod_en !== 1'b0 && k < 8)
        begin
            step(1);
            k++;
        end
        limit(k, 8, "force release");
    endtask

    task automatic t_thermal();
        int k;
        ratios = '{floor_ratio: 8'h12, nominal_ratio: 8'h13, max_ratio: 8'h14};
        FAR.set_temp(3, 8'h51);
        k = 0;
        while (package_hot_indicator_n !== 1'b0 && k < 40010)
        begin
            step(1);
            k++;
        end
        limit(k, 40010, "hot indicator");
        check("thermometer", 64'(core_thermo[3]), 64'h0000_0000_0000_0051);
        step(2);
        check("granted hot", 64'(turbo_granted), 64'h0000_0000_0000_0000);
        k = 0;
        while (thermal_target === 8'h14 && k < 4010)
        begin
            step(1);
            k++;
        end
        limit(k, 4010, "first step");
        check("target one step", 64'(thermal_target), 64'h0000_0000_0000_0013);
        step(3000);
        check("target held", 64'(thermal_target), 64'h0000_0000_0000_0013);
        k = 0;
        while (clock_mod_en !== 1'b1 && k < 9100)
        begin
            step(1);
            k++;
        end
        limit(k, 9100, "modulation");
        check("target floor", 64'(thermal_target), 64'h0000_0000_0000_0012);
        step(10);
        check("still modulating", 64'(clock_mod_en), 64'h0000_0000_0000_0001);
        check("still hot", 64'(package_hot_indicator_n), 64'h0000_0000_0000_0000);
    endtask

    initial
    begin
        err_total         = 0;
        n_checks          = 0;
        rst_n             = 1'b0;
        cfg_we            = 1'b0;
        cfg_feature_wdata = 64'h0000_0000_0000_0000;
        cfg_policy_wdata  = 2'h1;
        votes             = '0;
        thread_ratio_req  = '0;
        core_active       = 8'h03;
        trip_temp         = 8'h50;
        ratios            = '{floor_ratio: 8'h08, nominal_ratio: 8'h10, max_ratio: 8'h14};
        power_limit_ratio = 8'hff;
        for (int i = 0; i <= ttc_pkg::NUM_CORES; i++)
            uplift_table[i] = 8'(i);
        for (int t = 0; t < ttc_pkg::NUM_THREADS; t++)
            votes[t].deep_sleep = (t != 0 && t != 2);
        votes[0].wants_top = 1'b1;
        step(5);
        t_reset();
        rst_n = 1'b1;
        t_policy();
        t_disable();
        t_ratio();
        t_force();
        t_thermal();
        end_sim();
    end
endmodule
